// ===== shared/rms_map.vh
// Address map, field positions, reset values and timing constants of the radio mode/pairing block
//
// What this block does
// - Straps are sampled once after reset release; the board ties each strap high or low.
// - Straps 000 select active tag transmitter, 001 select switch-input transmitter.
// - Straps 01x select UART mode; 1xx select switch-output receiver mode.
// - Each device holds a fixed 32-bit serial identifier that users cannot alter.
// - Own serial identifier travels with every transmitted packet, invisible to user data.
// - Network mode, UART or receiver only, accepts data only from stored identifiers.
// - Teach pin idles as pulled-low input; high at least 20 ms then released starts learning.
// - During learning the teach pin becomes an output driven high.
// - While learning, store first sender's identifier and discard its data.
// - After storing a new identifier, flash the teach output on and off three times.
// - Leave learning after one identifier or 10 s; drive low, then release pin.
// - Store up to 60 distinct identifiers; no single identifier can be deleted.
// - Teach pin held high 10 s then released erases the whole identifier list.
// - After erasing, alternate the teach pin high and low for a few seconds.
// - With identifiers stored, accept data from stored senders only, reject all others.
// - Tag mode: activity pin is output, high per transmission; three switch inputs active high.
// - Tag mode with all switches low sends an identifier packet every 2 seconds.
// - Tag mode with any switch high reports all three switches every 15 ms.
// - Tag mode stays active 15 ms per transmission, low power otherwise.
`ifndef RMS_MAP_VH
`define RMS_MAP_VH

// ----------------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------------
`define RMS_ADDR_W        12
`define RMS_OFS_CTRL      12'h000
`define RMS_OFS_STATUS    12'h004
`define RMS_OFS_SERIAL    12'h008

`define RMS_CTRL_LEARN    0
`define RMS_CTRL_ERASE    1
`define RMS_CTRL_TXEN     2
`define RMS_TXEN_RST      1'b1

`define RMS_ST_MODE_LSB   0
`define RMS_ST_NET        4
`define RMS_ST_FSM_LSB    5
`define RMS_ST_CNT_LSB    10
`define RMS_ST_MVLD       16
`define RMS_ST_ACTIVE     17

// ----------------------------------------------------------------------
// Modes (one-hot)
// ----------------------------------------------------------------------
`define RMS_MODE_TAG      4'h1
`define RMS_MODE_SWTX     4'h2
`define RMS_MODE_UART     4'h4
`define RMS_MODE_RCV      4'h8
`define RMS_BIT_TAG       0
`define RMS_BIT_UART      2
`define RMS_BIT_RCV       3
`define RMS_STRAP_WAIT    2'h3

// ----------------------------------------------------------------------
// Timing: clock period and ms figures, ms tick derived from them
// ----------------------------------------------------------------------
`define RMS_CLK_PERIOD_PS 4000
`define RMS_MS_PS         1000000000
`define RMS_MS_CYC        (`RMS_MS_PS / `RMS_CLK_PERIOD_PS)
`define RMS_LEARN_MIN_MS  14'h0014
`define RMS_CLEAR_MS      14'h2710
`define RMS_LEARN_TMO_MS  14'h2710
`define RMS_BEACON_MS     14'h07d0
`define RMS_SWREP_MS      14'h000f
`define RMS_ACTIVE_MS     14'h000f
`define RMS_FLASH_MS      14'h0032
`define RMS_ACK_EDGES     4'h6
`define RMS_ERASE_HALF_MS 14'h00fa
`define RMS_ERASE_EDGES   4'hc
`define RMS_EXIT_MS       14'h0001
`define RMS_LIST_DEPTH    6'h3c

`endif

// ===== logic/rms_id_store.v
// Identifier list memory, one write port, registered read data
`timescale 1ns/1ps
module rms_id_store (
   input  wire        i_clk,
   input  wire        i_we,
   input  wire [5:0]  i_addr,
   input  wire [31:0] i_wdata,
   output reg  [31:0] o_rdata
);
   reg [31:0] mem [0:63];

   // No reset on contents: erasing the list only clears the entry count
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end
endmodule // rms_id_store

// ===== logic/rms_top.v
// Mode straps, serial identifier, teach-pin pairing and active tag timing
`timescale 1ns/1ps
`include "rms_map.vh"
module rms_top #(
   parameter integer P_MS_CYC    = `RMS_MS_CYC,
   parameter [31:0]  P_SERIAL_ID = 32'h5a3c_0001   // Arbitrary value
) (
   input  wire        I_CLK_SYS,
   input  wire        I_RESET_N,
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output wire [31:0] O_PRDATA,
   output wire        O_PREADY,
   output wire        O_PSLVERR,
   input  wire        I_MODE_STRAP_LOW,
   input  wire        I_MODE_STRAP_MID,
   input  wire        I_MODE_STRAP_HIGH,
   input  wire        I_TEACH_OR_ACTIVITY_PIN,
   output wire        O_TEACH_OR_ACTIVITY_PIN,
   output wire        O_TEACH_OR_ACTIVITY_PIN_OE,
   input  wire        I_SWITCH_IN_ONE,
   input  wire        I_SWITCH_IN_TWO,
   input  wire        I_SWITCH_IN_THREE,
   input  wire        I_RX_VALID,
   input  wire [31:0] I_RX_SRC_ID,
   output wire        O_RX_READY,
   output wire        O_RX_ACCEPT,
   output wire        O_RX_REJECT,
   output wire        O_TX_REQ,
   output wire        O_TX_SWITCH_REPORT,
   output wire [2:0]  O_TX_SWITCHES,
   output wire [31:0] O_TX_ID,
   output wire        O_LOW_POWER
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_LEARN = 5'h02;
   localparam [4:0] S_ACK   = 5'h04;
   localparam [4:0] S_EXIT  = 5'h08;
   localparam [4:0] S_ERASE = 5'h10;
   localparam [17:0] ms_last = P_MS_CYC[17:0] - 18'h1;

   reg  [6:0]  sy1_ff;
   reg  [6:0]  sy2_ff;
   reg  [1:0]  st_cnt_ff;
   reg         mode_vld_ff;
   reg  [3:0]  mode_ff;
   reg         net_ff;
   reg  [17:0] ms_cnt_ff;
   reg         tick_ff;
   reg  [4:0]  st_ff;
   reg  [13:0] tm_ff;
   reg  [13:0] hi_ms_ff;
   reg  [3:0]  edges_ff;
   reg         pin_do_ff;
   reg         pin_oe_ff;
   reg         teach_prev_ff;
   reg  [5:0]  cnt_ff;
   reg         sc_busy_ff;
   reg         sc_rdv_ff;
   reg         sc_learn_ff;
   reg  [5:0]  sc_idx_ff;
   reg  [31:0] sc_id_ff;
   reg         rx_acc_ff;
   reg         rx_rej_ff;
   reg  [31:0] prdata_ff;
   reg         txen_ff;
   reg  [13:0] tg_ms_ff;
   reg  [13:0] act_ms_ff;
   reg         active_ff;
   reg         prev_any_ff;
   reg         tx_req_ff;
   reg         tx_kind_ff;
   reg  [2:0]  tx_sw_ff;
   reg         nxt_pin_do;
   reg         nxt_pin_oe;
   wire [31:0] rd_data;
   wire        teach_lvl;
   wire [2:0]  sw_lvl;
   wire        any_sw;
   wire        net_mode;
   wire        rx_mode;
   wire        tag_mode;
   wire        sc_empty;
   wire        sc_hit;
   wire        sc_last;
   wire        sc_done;
   wire        wr_new;
   wire        teach_fall;
   wire        apb_wr;
   wire        apb_map;
   wire        sw_learn;
   wire        sw_erase;
   wire        go_erase;
   wire        go_learn;
   wire        send;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function [3:0] f_mode;
      input [2:0] straps;
      begin
         casez (straps)
            3'b1??:  f_mode = `RMS_MODE_RCV;
            3'b01?:  f_mode = `RMS_MODE_UART;
            3'b001:  f_mode = `RMS_MODE_SWTX;
            default: f_mode = `RMS_MODE_TAG;
         endcase
      end
   endfunction

   // Timer step: true at the tick that closes a span of len ms
   function f_span_end;
      input [13:0] t;
      input [13:0] len;
      input        tk;
      begin
         f_span_end = tk & (t >= len - 14'h1);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers and strap capture
   // ----------------------------------------------------------------------
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sy1_ff <= 7'h00;
         sy2_ff <= 7'h00;
      end else begin
         sy1_ff <= {I_SWITCH_IN_THREE, I_SWITCH_IN_TWO, I_SWITCH_IN_ONE, I_TEACH_OR_ACTIVITY_PIN,
                    I_MODE_STRAP_HIGH, I_MODE_STRAP_MID, I_MODE_STRAP_LOW};
         sy2_ff <= sy1_ff;
      end
   end

   assign teach_lvl = sy2_ff[3];
   assign sw_lvl    = sy2_ff[6:4];
   assign any_sw    = |sw_lvl;
   // Straps caught once the synchroniser has filled after release
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_cnt_ff   <= 2'h0;
         mode_vld_ff <= 1'b0;
         mode_ff     <= 4'h0;
         net_ff      <= 1'b0;
      end else if (!mode_vld_ff) begin
         if (st_cnt_ff == `RMS_STRAP_WAIT) begin
            mode_ff     <= f_mode(sy2_ff[2:0]);
            net_ff      <= sy2_ff[0];
            mode_vld_ff <= 1'b1;
         end else begin
            st_cnt_ff <= st_cnt_ff + 2'h1;
         end
      end
   end

   assign rx_mode  = mode_vld_ff & (mode_ff[`RMS_BIT_UART] | mode_ff[`RMS_BIT_RCV]);
   assign net_mode = rx_mode & net_ff;
   assign tag_mode = mode_vld_ff & mode_ff[`RMS_BIT_TAG];

   // ----------------------------------------------------------------------
   // Millisecond tick
   // ----------------------------------------------------------------------
   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ms_cnt_ff <= 18'h0;
         tick_ff   <= 1'b0;
      end else begin
         tick_ff   <= (ms_cnt_ff == ms_last);
         ms_cnt_ff <= (ms_cnt_ff == ms_last) ? 18'h0 : ms_cnt_ff + 18'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   assign apb_map  = (I_PADDR == `RMS_OFS_CTRL) | (I_PADDR == `RMS_OFS_STATUS) | (I_PADDR == `RMS_OFS_SERIAL);
   assign apb_wr   = I_PSEL & I_PENABLE & I_PWRITE & (I_PADDR == `RMS_OFS_CTRL);
   assign sw_learn = apb_wr & I_PWDATA[`RMS_CTRL_LEARN];
   assign sw_erase = apb_wr & I_PWDATA[`RMS_CTRL_ERASE];
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~apb_map;
   assign O_PRDATA  = prdata_ff;

   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         prdata_ff <= 32'h0;
         txen_ff   <= `RMS_TXEN_RST;
      end else begin
         if (apb_wr) begin
            txen_ff <= I_PWDATA[`RMS_CTRL_TXEN];
         end
         if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
            case (I_PADDR)
               `RMS_OFS_CTRL:   prdata_ff <= {29'h0, txen_ff, 2'h0};
               `RMS_OFS_STATUS: prdata_ff <= {14'h0, active_ff, mode_vld_ff, cnt_ff, st_ff, net_mode, mode_ff};
               `RMS_OFS_SERIAL: prdata_ff <= P_SERIAL_ID;
               default:         prdata_ff <= 32'h0;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Identifier list and lookup
   // ----------------------------------------------------------------------
   // One entry per two cycles; the sender waits on O_RX_READY meanwhile
   assign sc_empty = (cnt_ff == 6'h00);
   assign sc_hit   = sc_rdv_ff & ~sc_empty & (rd_data == sc_id_ff);
   assign sc_last  = (sc_idx_ff + 6'h1 >= cnt_ff);
   assign sc_done  = sc_busy_ff & (sc_empty | (sc_rdv_ff & (sc_hit | sc_last)));
   assign wr_new   = sc_done & sc_learn_ff & ~sc_hit & (cnt_ff < `RMS_LIST_DEPTH);
   assign O_RX_READY  = ~sc_busy_ff;
   assign O_RX_ACCEPT = rx_acc_ff;
   assign O_RX_REJECT = rx_rej_ff;

   rms_id_store u_store (
      .i_clk   (I_CLK_SYS),
      .i_we    (wr_new),
      .i_addr  (wr_new ? cnt_ff : sc_idx_ff),
      .i_wdata (sc_id_ff),
      .o_rdata (rd_data)
   );

   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sc_busy_ff  <= 1'b0;
         sc_rdv_ff   <= 1'b0;
         sc_learn_ff <= 1'b0;
         sc_idx_ff   <= 6'h00;
         sc_id_ff    <= 32'h0;
         rx_acc_ff   <= 1'b0;
         rx_rej_ff   <= 1'b0;
         cnt_ff      <= 6'h00;
      end else begin
         rx_acc_ff <= 1'b0;
         rx_rej_ff <= 1'b0;
         if (go_erase) begin
            cnt_ff <= 6'h00;
         end else if (wr_new) begin
            cnt_ff <= cnt_ff + 6'h1;
         end
         if (!sc_busy_ff) begin
            if (I_RX_VALID) begin
               if (rx_mode & (net_mode | st_ff[1])) begin
                  sc_busy_ff  <= 1'b1;
                  sc_rdv_ff   <= 1'b0;
                  sc_idx_ff   <= 6'h00;
                  sc_id_ff    <= I_RX_SRC_ID;
                  sc_learn_ff <= st_ff[1];
               end else begin
                  rx_acc_ff <= rx_mode;
                  rx_rej_ff <= ~rx_mode;
               end
            end
         end else if (sc_done) begin
            sc_busy_ff <= 1'b0;
            rx_acc_ff  <= ~sc_learn_ff & sc_hit;
            rx_rej_ff  <= sc_learn_ff | ~sc_hit;
         end else if (sc_rdv_ff) begin
            sc_idx_ff <= sc_idx_ff + 6'h1;
            sc_rdv_ff <= 1'b0;
         end else begin
            sc_rdv_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Teach pin sequencer
   // ----------------------------------------------------------------------
   // Pin is only read while released, so own drive never looks like a press
   assign teach_fall = teach_prev_ff & ~teach_lvl & ~pin_oe_ff;
   assign go_erase = st_ff[0] & net_mode & ((teach_fall & (hi_ms_ff >= `RMS_CLEAR_MS)) | sw_erase);
   assign go_learn = st_ff[0] & net_mode & ~go_erase &
                     ((teach_fall & (hi_ms_ff >= `RMS_LEARN_MIN_MS)) | sw_learn);

   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_ff         <= S_IDLE;
         tm_ff         <= 14'h0;
         hi_ms_ff      <= 14'h0;
         edges_ff      <= 4'h0;
         teach_prev_ff <= 1'b0;
      end else begin
         teach_prev_ff <= teach_lvl & ~pin_oe_ff;
         if (tick_ff) begin
            tm_ff <= tm_ff + 14'h1;
         end
         case (st_ff)
            S_IDLE: begin
               if (~teach_lvl | pin_oe_ff) begin
                  hi_ms_ff <= 14'h0;
               end else if (tick_ff & (hi_ms_ff != 14'h3fff)) begin
                  hi_ms_ff <= hi_ms_ff + 14'h1;
               end
               tm_ff    <= 14'h0;
               edges_ff <= 4'h0;
               if (go_erase) begin
                  st_ff <= S_ERASE;
               end else if (go_learn) begin
                  st_ff <= S_LEARN;
               end
            end
            S_LEARN: begin
               if (sc_done & sc_learn_ff) begin
                  st_ff <= wr_new ? S_ACK : S_EXIT;
                  tm_ff <= 14'h0;
               end else if (f_span_end(tm_ff, `RMS_LEARN_TMO_MS, tick_ff)) begin
                  st_ff <= S_EXIT;
                  tm_ff <= 14'h0;
               end
            end
            S_ACK, S_ERASE: begin
               if (f_span_end(tm_ff, st_ff[2] ? `RMS_FLASH_MS : `RMS_ERASE_HALF_MS, tick_ff)) begin
                  tm_ff    <= 14'h0;
                  edges_ff <= edges_ff + 4'h1;
                  if (edges_ff == (st_ff[2] ? `RMS_ACK_EDGES : `RMS_ERASE_EDGES) - 4'h1) begin
                     st_ff <= S_EXIT;
                  end
               end
            end
            S_EXIT: begin
               if (f_span_end(tm_ff, `RMS_EXIT_MS, tick_ff)) begin
                  st_ff <= S_IDLE;
               end
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end

   // Pin drive; tag mode lends the pin to the activity indicator
   always @* begin
      nxt_pin_oe = 1'b0;
      nxt_pin_do = 1'b0;
      if (tag_mode) begin
         nxt_pin_oe = 1'b1;
         nxt_pin_do = active_ff;
      end else begin
         case (st_ff)
            S_LEARN: begin
               nxt_pin_oe = 1'b1;
               nxt_pin_do = 1'b1;
            end
            S_ACK: begin
               nxt_pin_oe = 1'b1;
               nxt_pin_do = edges_ff[0];  // Starts low so three flashes follow learn high
            end
            S_ERASE: begin
               nxt_pin_oe = 1'b1;
               nxt_pin_do = edges_ff[0];
            end
            S_EXIT: begin
               nxt_pin_oe = 1'b1;
               nxt_pin_do = 1'b0;
            end
            default: begin
               nxt_pin_oe = 1'b0;
               nxt_pin_do = 1'b0;
            end
         endcase
      end
   end

   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         pin_oe_ff <= 1'b0;
         pin_do_ff <= 1'b0;
      end else begin
         pin_oe_ff <= nxt_pin_oe;
         pin_do_ff <= nxt_pin_do;
      end
   end

   assign O_TEACH_OR_ACTIVITY_PIN    = pin_do_ff;
   assign O_TEACH_OR_ACTIVITY_PIN_OE = pin_oe_ff;

   // ----------------------------------------------------------------------
   // Active tag transmitter
   // ----------------------------------------------------------------------
   // A fresh switch press is reported at once rather than at the next slot
   assign send = tag_mode & txen_ff &
                 ((any_sw & ~prev_any_ff) |
                  f_span_end(tg_ms_ff, any_sw ? `RMS_SWREP_MS : `RMS_BEACON_MS, tick_ff));

   always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         tg_ms_ff    <= 14'h0;
         act_ms_ff   <= 14'h0;
         active_ff   <= 1'b0;
         prev_any_ff <= 1'b0;
         tx_req_ff   <= 1'b0;
         tx_kind_ff  <= 1'b0;
         tx_sw_ff    <= 3'h0;
      end else begin
         prev_any_ff <= any_sw & tag_mode;
         tx_req_ff   <= send;
         if (send) begin
            tg_ms_ff   <= 14'h0;
            act_ms_ff  <= 14'h0;
            active_ff  <= 1'b1;
            tx_kind_ff <= any_sw;
            tx_sw_ff   <= sw_lvl;
         end else begin
            if (tick_ff & tag_mode) begin
               tg_ms_ff <= tg_ms_ff + 14'h1;
            end
            if (active_ff & tick_ff) begin
               act_ms_ff <= act_ms_ff + 14'h1;
            end
            if (f_span_end(act_ms_ff, `RMS_ACTIVE_MS, tick_ff & active_ff)) begin
               active_ff <= 1'b0;
            end
         end
      end
   end

   assign O_TX_REQ           = tx_req_ff;
   assign O_TX_SWITCH_REPORT = tx_kind_ff;
   assign O_TX_SWITCHES      = tx_sw_ff;
   assign O_TX_ID            = P_SERIAL_ID;
   assign O_LOW_POWER        = tag_mode & ~active_ff;
endmodule // rms_top

// ===== dv/rms_checker_assertions.sv
// Port-level assertions for the mode, pairing and tag timing block
`timescale 1ns/1ps
module rms_checker #(
   parameter integer P_MS_CYC    = 10,
   parameter [31:0]  P_SERIAL_ID = 32'h5a3c_0001   // Arbitrary value
) (
   input wire logic        I_CLK_SYS,
   input wire logic        I_RESET_N,
   input wire logic        I_RX_VALID,
   input wire logic        O_RX_READY,
   input wire logic        O_RX_ACCEPT,
   input wire logic        O_RX_REJECT,
   input wire logic        O_TX_REQ,
   input wire logic        O_TX_SWITCH_REPORT,
   input wire logic [2:0]  O_TX_SWITCHES,
   input wire logic [31:0] O_TX_ID,
   input wire logic        O_LOW_POWER,
   input wire logic        O_TEACH_OR_ACTIVITY_PIN,
   input wire logic        O_TEACH_OR_ACTIVITY_PIN_OE
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   property p_id_fixed; O_TX_ID == P_SERIAL_ID; endproperty
   a_id_fixed: assert property (p_id_fixed) else $error("identifier changed");
   property p_one_verdict; !(O_RX_ACCEPT && O_RX_REJECT); endproperty
   a_one_verdict: assert property (p_one_verdict) else $error("accept and reject together");
   // Longest lookup is a full list of 60 entries
   property p_verdict_bound; I_RX_VALID && O_RX_READY |=> ##[0:124] (O_RX_ACCEPT || O_RX_REJECT); endproperty
   a_verdict_bound: assert property (p_verdict_bound) else $error("no verdict on packet");
   property p_tx_single; O_TX_REQ |=> !O_TX_REQ; endproperty
   a_tx_single: assert property (p_tx_single) else $error("send request too long");
   property p_wake; O_TX_REQ |=> !O_LOW_POWER [*8]; endproperty
   a_wake: assert property (p_wake) else $error("low power during send");
   property p_activity; O_TX_REQ |=> ##[0:1] (O_TEACH_OR_ACTIVITY_PIN && O_TEACH_OR_ACTIVITY_PIN_OE); endproperty
   a_activity: assert property (p_activity) else $error("activity pin not high");
   property p_report; O_TX_REQ && O_TX_SWITCH_REPORT |-> O_TX_SWITCHES != 3'h0; endproperty
   a_report: assert property (p_report) else $error("switch report with all low");
   property p_exit_low; $fell(O_TEACH_OR_ACTIVITY_PIN_OE) |-> !$past(O_TEACH_OR_ACTIVITY_PIN); endproperty
   a_exit_low: assert property (p_exit_low) else $error("pin released while high");
endmodule // rms_checker

bind rms_top rms_checker #(.P_MS_CYC(P_MS_CYC), .P_SERIAL_ID(P_SERIAL_ID)) rms_checker_inst (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .I_RX_VALID(I_RX_VALID), .O_RX_READY(O_RX_READY),
   .O_RX_ACCEPT(O_RX_ACCEPT), .O_RX_REJECT(O_RX_REJECT), .O_TX_REQ(O_TX_REQ),
   .O_TX_SWITCH_REPORT(O_TX_SWITCH_REPORT), .O_TX_SWITCHES(O_TX_SWITCHES), .O_TX_ID(O_TX_ID),
   .O_LOW_POWER(O_LOW_POWER), .O_TEACH_OR_ACTIVITY_PIN(O_TEACH_OR_ACTIVITY_PIN),
   .O_TEACH_OR_ACTIVITY_PIN_OE(O_TEACH_OR_ACTIVITY_PIN_OE));

// ===== dv/rms_far_end.sv
// Remote sender and teach button model
`timescale 1ns/1ps
module rms_far_end (
   input  wire logic        i_clk,
   input  wire logic        i_pin_o,
   input  wire logic        i_pin_oe,
   input  wire logic        i_rx_ready,
   output wire logic        o_pin,
   output logic             o_rx_valid,
   output logic [31:0]      o_rx_src_id
);
   logic press_ff = 1'b0;
   initial o_rx_valid = 1'b0;
   initial o_rx_src_id = 32'h0;
   // Pull-down wins when nobody drives
   assign o_pin = i_pin_oe ? i_pin_o : press_ff;
   // ------------------------------------------------------------------
   // Button press of given cycles, then release
   // ------------------------------------------------------------------
   task hold(input int cycles);
      press_ff <= 1'b1;
      repeat (cycles) @(posedge i_clk);
      press_ff <= 1'b0;
   endtask
   // Held until taken; released id shows its inverse
   task send(input logic [31:0] id);
      o_rx_valid  <= 1'b1;
      o_rx_src_id <= id;
      do @(posedge i_clk); while (i_rx_ready !== 1'b1);
      o_rx_valid  <= 1'b0;
      o_rx_src_id <= ~id;
      @(posedge i_clk);
   endtask
endmodule // rms_far_end

// ===== dv/rms_top_bench.sv
// Self-checking bench for the mode, pairing and tag timing block
`timescale 1ns/1ps
module rms_top_bench;
   localparam integer  MS  = 2;
   localparam [31:0]   SID = 32'h5a3c_0001;   // Arbitrary value
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [2:0]  strap = 3'h0, sw = 3'h0;
   wire  [31:0] prdata, rx_id;
   wire  [2:0]  txsw;
   wire         pready, pslverr, pin_o, pin_oe, pin, rx_valid, rx_ready, acc, rej, txreq, txrep, lowp;
   int mismatches = 0, samples_checked = 0, cyc = 0, n_acc = 0, n_rej = 0, n_req = 0, n_rise = 0;
   int t_last = 0, t_prev = 0, r0, b;
   logic pin_q = 1'b0;

   rms_top #(.P_MS_CYC(MS), .P_SERIAL_ID(SID)) rms_top_inst (.I_CLK_SYS(clk), .I_RESET_N(rst_n),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_MODE_STRAP_LOW(strap[0]), .I_MODE_STRAP_MID(strap[1]),
      .I_MODE_STRAP_HIGH(strap[2]), .I_TEACH_OR_ACTIVITY_PIN(pin), .O_TEACH_OR_ACTIVITY_PIN(pin_o),
      .O_TEACH_OR_ACTIVITY_PIN_OE(pin_oe), .I_SWITCH_IN_ONE(sw[0]), .I_SWITCH_IN_TWO(sw[1]),
      .I_SWITCH_IN_THREE(sw[2]), .I_RX_VALID(rx_valid), .I_RX_SRC_ID(rx_id), .O_RX_READY(rx_ready),
      .O_RX_ACCEPT(acc), .O_RX_REJECT(rej), .O_TX_REQ(txreq), .O_TX_SWITCH_REPORT(txrep),
      .O_TX_SWITCHES(txsw), .O_TX_ID(), .O_LOW_POWER(lowp));
   rms_far_end rms_far_end_inst (.i_clk(clk), .i_pin_o(pin_o), .i_pin_oe(pin_oe), .i_rx_ready(rx_ready),
      .o_pin(pin), .o_rx_valid(rx_valid), .o_rx_src_id(rx_id));

   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc    <= cyc + 1;
      pin_q  <= pin_o;
      n_acc  <= n_acc + int'(acc === 1'b1);
      n_rej  <= n_rej + int'(rej === 1'b1);
      n_rise <= n_rise + int'(pin_o === 1'b1 && pin_q === 1'b0);
      if (txreq === 1'b1) begin
         t_prev <= t_last;
         t_last <= cyc;
         n_req  <= n_req + 1;
      end
      if (cyc == 90000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task boot(input logic [2:0] s);
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= s;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask
   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      for (int s = 0; s < 8; s++) begin
         boot(3'(s));
         apb(1'b0, 12'h004, 32'h0);
         chk("mode", rd & 32'hf, s[2] ? 32'h8 : s[1] ? 32'h4 : s[0] ? 32'h2 : 32'h1);
         chk("network", 32'(rd[4]), 32'(s[0] & (s[2] | s[1])));
      end
      apb(1'b0, 12'h008, 32'h0);
      chk("serial", rd, SID);
      apb(1'b1, 12'h008, ~SID);
      apb(1'b0, 12'h008, 32'h0);
      chk("serial_locked", rd, SID);
      apb(1'b0, 12'h0f0, 32'h0);
      chk("unmapped_err", 32'(err), 32'h1);
      rms_far_end_inst.send(32'h1111_0001);
      repeat (4) @(posedge clk);
      chk("empty_list_reject", 32'(n_rej), 32'h1);
      rms_far_end_inst.hold(25 * MS);
      repeat (12) @(posedge clk);
      chk("learn_drive", {30'h0, pin_oe, pin_o}, 32'h3);
      r0 = n_rise;
      rms_far_end_inst.send(32'hcafe_0042);
      repeat (4) @(posedge clk);
      chk("learn_discard", 32'(n_acc * 16 + n_rej), 32'h2);
      repeat (310 * MS) @(posedge clk);
      chk("flash_count", 32'(n_rise - r0), 32'h3);
      chk("pin_released", 32'(pin_oe), 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      chk("stored", (rd >> 10) & 32'h3f, 32'h1);
      rms_far_end_inst.send(32'hcafe_0042);
      rms_far_end_inst.send(32'h1111_0001);
      repeat (4) @(posedge clk);
      chk("filter", 32'(n_acc * 16 + n_rej), 32'h13);
      apb(1'b1, 12'h000, 32'h5);
      repeat (10010 * MS) @(posedge clk);
      chk("learn_timeout", 32'(pin_oe), 32'h0);
      rms_far_end_inst.hold(10002 * MS);
      repeat (20) @(posedge clk);
      r0 = n_rise;
      apb(1'b0, 12'h004, 32'h0);
      chk("erased", (rd >> 10) & 32'h3f, 32'h0);
      repeat (3010 * MS) @(posedge clk);
      chk("erase_blink", 32'(n_rise - r0), 32'h6);
      boot(3'h0);
      chk("tag_pin_out", 32'(pin_oe), 32'h1);
      b = n_req;
      while (n_req < b + 2) @(posedge clk);
      chk("beacon_gap", 32'(t_last - t_prev), 32'(2000 * MS));
      chk("beacon_kind", 32'(txrep), 32'h0);
      repeat (40 * MS) @(posedge clk);
      chk("sleep", 32'(lowp), 32'h1);
      sw <= 3'h5;
      b = n_req;
      while (n_req < b + 3) @(posedge clk);
      chk("report_gap", 32'(t_last - t_prev), 32'(15 * MS));
      chk("report", {28'h0, txrep, txsw}, 32'hd);
      sw <= 3'h0;
      repeat (40 * MS) @(posedge clk);
      summarize;
   end
endmodule // rms_top_bench
